// ==== include/pise_pkg.sv ====
// Package for the interrupt status and event control block
package pise_pkg;

  // ==========================================================
  // Register map
  localparam logic [4:0] MISC_ADDR = 5'h12; // Status and event control register
  localparam logic [4:0] CFG_ADDR = 5'h1a; // Mode select register
  localparam logic [4:0] IRQ_STAT_ADDR = 5'h1b; // Sticky event status
  localparam logic [4:0] IRQ_MASK_ADDR = 5'h1c; // Event mask

  // ==========================================================
  // Field positions in the status and event control register
  localparam int PEND_BIT = 8; // Shared pending status bit
  localparam int EN_LQ = 7; // Link quality enable
  localparam int EN_ED = 6; // Energy detect enable
  localparam int EN_LINK = 5; // Link change enable
  localparam int EN_SPD = 4; // Speed change enable
  localparam int EN_DUP = 3; // Duplex or time-sync enable
  localparam int EN_ANC = 2; // Autoneg done enable
  localparam int EN_FC = 1; // False carrier or any counter enable
  localparam int EN_RX = 0; // Rx error or control frame enable

  // Config register fields
  localparam int CFG_CMODE_LO = 0; // Counter mode field, two bits
  localparam int CFG_MODE_HI_IDX = 1; // Counter mode field, high bit
  localparam int CFG_FSEL = 2; // Interrupt function select

  // ==========================================================
  // Reset values
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // Event index in sticky status register
  localparam int EV_PENDREAD = 0; // Shared pending bit cleared by a read
  localparam int EV_ENABLED = 1; // Any enabled event seen

endpackage

// ==== rtl/pise_event_latch.sv ====
// Pending bit latch with set-priority over read clear
`timescale 1ns/10ps
`default_nettype none

module pise_event_latch (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic setPulse,
  input wire logic clearPulse,
  input wire logic armOk,
  // State
  output logic pendingReg
);

  // ==========================================================
  // Latch: set wins, re-arm gated by armOk
  logic armed_reg;

  // Pending bit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pendingReg <= 1'b0;
    end else if (setPulse && armed_reg) begin
      pendingReg <= 1'b1;
    end else if (clearPulse) begin
      pendingReg <= 1'b0;
    end
  end

  // Arming: disarmed after a set while armOk is low, re-armed when armOk
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_reg <= 1'b1;
    end else if (setPulse && armed_reg && !armOk) begin
      armed_reg <= 1'b0;
    end else if (armOk) begin
      armed_reg <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/pise_top.sv ====
// Interrupt status and event control register block
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// Function
// [RULE1] Mode zero: bit 8 rx-error half-full, clear-on-read
// [RULE2] Other mode: bit 8 control frame, clear-on-read
// [RULE3] Bit 7 link quality enable, reset 0
// [RULE4] Bit 6 energy detect enable, reset 0
// [RULE5] Bit 5 link change enable, reset 0
// [RULE6] Bit 4 speed change enable, reset 0
// [RULE7] Bit 3 duplex or time-sync by select
// [RULE8] Bit 2 autoneg done enable, reset 0
// [RULE9] Bit 1 false-carrier half-full in mode zero
// [RULE10] Bit 1 either counter half-full otherwise
// [RULE11] Bit 0 rx-error half-full in mode zero
// [RULE12] Bit 0 control frame otherwise
// [RULE13] Time-sync rearms only when status empty
// [RULE14] Interrupt while enabled pending bit set
module pise_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // Event sources, pins
  input wire logic linkQualityEvent,
  input wire logic energyDetectEvent,
  input wire logic linkChangeEvent,
  input wire logic speedChangeEvent,
  input wire logic duplexChangeEvent,
  input wire logic timeSyncEvent,
  input wire logic timeSyncStatusEmpty,
  input wire logic autonegDoneEvent,
  input wire logic falseCarrierHalfFull,
  input wire logic rxErrorHalfFull,
  input wire logic controlFrameEvent,
  // Interrupt outputs
  output logic phyIrq,
  output logic irqOut
);

  // ==========================================================
  // Input synchronisers
  logic [10:0] evMeta_reg; // First stage, read only by second stage
  logic [10:0] evSync_reg; // Second stage
  logic [10:0] evPrev_reg; // Edge detect history
  logic [10:0] evRise; // One-cycle event pulses

  // An event reaches the logic two edges after its pin rises, so a
  // pin must stay high for at least one clock or its edge may be lost.
  // Two flip-flops per pin before any logic
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      evMeta_reg <= 11'h000;
      evSync_reg <= 11'h000;
      evPrev_reg <= 11'h000;
    end else begin
      evMeta_reg <= {timeSyncStatusEmpty, linkQualityEvent, energyDetectEvent,
                     linkChangeEvent, speedChangeEvent, duplexChangeEvent,
                     timeSyncEvent, autonegDoneEvent, falseCarrierHalfFull,
                     rxErrorHalfFull, controlFrameEvent};
      evSync_reg <= evMeta_reg;
      evPrev_reg <= evSync_reg;
    end
  end

  // Rising edges; status-empty stays a level
  assign evRise = evSync_reg & ~evPrev_reg;

  logic tsEmpty; // Time-sync status reports empty, a level
  logic lqEv; // Link quality event pulse
  logic edEv; // Energy detect event pulse
  logic lnkEv; // Link change event pulse
  logic spdEv; // Speed change event pulse
  logic dupEv; // Duplex change event pulse
  logic tsEv; // Time-sync event pulse
  logic ancEv; // Autoneg done event pulse
  logic fcEv; // False carrier half-full pulse
  logic rxEv; // Rx error half-full pulse
  logic cfEv; // Control frame event pulse
  assign tsEmpty = evSync_reg[10];
  assign lqEv = evRise[9];
  assign edEv = evRise[8];
  assign lnkEv = evRise[7];
  assign spdEv = evRise[6];
  assign dupEv = evRise[5];
  assign tsEv = evRise[4];
  assign ancEv = evRise[3];
  assign fcEv = evRise[2];
  assign rxEv = evRise[1];
  assign cfEv = evRise[0];

  // ==========================================================
  // Software registers
  logic [7:0] enable_reg; // Event enables, bits 7..0
  logic [2:0] cfg_reg; // Counter mode and function select
  logic [1:0] irqStat_reg; // Sticky status
  logic [1:0] irqMask_reg; // Mask for irqOut

  // Decode of a write to one address
  function automatic logic wrHit(input logic [4:0] a, input logic w, input logic [4:0] t);
    return w && (a == t);
  endfunction

  // Enable bits, all read-write and reset to zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_reg <= pise_pkg::EN_RESET; // RULE3 RULE4 RULE5 RULE6 RULE8
    end else if (wrHit(regAddr, regWrite, pise_pkg::MISC_ADDR)) begin
      enable_reg <= regWdata[7:0]; // RULE3 RULE4 RULE5 RULE6 RULE8
    end
  end

  // Mode select register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= pise_pkg::CFG_RESET;
    end else if (wrHit(regAddr, regWrite, pise_pkg::CFG_ADDR)) begin
      cfg_reg <= regWdata[2:0];
    end
  end

  // Any nonzero counter mode selects the alternate sources for bits 8, 1 and 0
  logic altMode; // Either counter mode bit set
  logic fnSel; // Time-sync function selected
  assign altMode = |cfg_reg[pise_pkg::CFG_MODE_HI_IDX:pise_pkg::CFG_CMODE_LO];
  assign fnSel = cfg_reg[pise_pkg::CFG_FSEL];

  // ==========================================================
  // Shared pending bit 8
  logic pendSet; // Source for bit 8 by mode
  logic miscRead; // Read of the status register
  logic pendState; // Latched pending bit
  assign pendSet = altMode ? cfEv : rxEv; // RULE1 RULE2
  assign miscRead = regRead && (regAddr == pise_pkg::MISC_ADDR);

  // A read in the cycle of a new set returns 0 but leaves the bit pending,
  // so the event shows on the next read rather than being lost.
  // Pending latch, cleared by the read, set wins
  pise_event_latch uPend (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .setPulse(pendSet),
    .clearPulse(miscRead), // RULE1 RULE2
    .armOk(1'b1),
    .pendingReg(pendState)
  );

  // ==========================================================
  // Time-sync arming: one raise, then wait for empty status
  // From the cycle after the status reports empty every event passes; the disarm only
  // holds back repeats while software still has status to drain.
  logic tsArmed_reg;
  logic tsGated;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tsArmed_reg <= 1'b1;
    end else if (tsEv && tsArmed_reg && !tsEmpty) begin
      tsArmed_reg <= 1'b0; // RULE13
    end else if (tsEmpty) begin
      tsArmed_reg <= 1'b1; // RULE13
    end
  end
  assign tsGated = tsEv && tsArmed_reg;

  // ==========================================================
  // Enabled event detection
  logic [7:0] evVec;
  always_comb begin
    evVec = 8'h00;
    evVec[pise_pkg::EN_LQ] = lqEv;
    evVec[pise_pkg::EN_ED] = edEv;
    evVec[pise_pkg::EN_LINK] = lnkEv;
    evVec[pise_pkg::EN_SPD] = spdEv;
    evVec[pise_pkg::EN_DUP] = fnSel ? tsGated : dupEv; // RULE7 RULE13
    evVec[pise_pkg::EN_ANC] = ancEv;
    evVec[pise_pkg::EN_FC] = altMode ? (fcEv | rxEv) : fcEv; // RULE9 RULE10
    evVec[pise_pkg::EN_RX] = altMode ? cfEv : rxEv; // RULE11 RULE12
  end

  logic anyEnabled;
  assign anyEnabled = |(evVec & enable_reg);

  // Enabled events held until the status register is read
  logic enPend_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      enPend_reg <= 1'b0;
    end else if (anyEnabled) begin
      enPend_reg <= 1'b1; // RULE14
    end else if (miscRead) begin
      enPend_reg <= 1'b0; // RULE14
    end
  end

  // Device interrupt line
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phyIrq <= 1'b0;
    end else begin
      phyIrq <= (enPend_reg && !miscRead) || anyEnabled; // RULE14
    end
  end

  // ==========================================================
  // Sticky status and mask
  logic [1:0] irqEv;
  assign irqEv = {anyEnabled, pendSet};

  // Set wins over write-one-to-clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_reg <= pise_pkg::IRQ_RESET;
    end else if (wrHit(regAddr, regWrite, pise_pkg::IRQ_STAT_ADDR)) begin
      irqStat_reg <= (irqStat_reg & ~regWdata[1:0]) | irqEv;
    end else begin
      irqStat_reg <= irqStat_reg | irqEv;
    end
  end

  // Mask register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqMask_reg <= pise_pkg::IRQ_RESET;
    end else if (wrHit(regAddr, regWrite, pise_pkg::IRQ_MASK_ADDR)) begin
      irqMask_reg <= regWdata[1:0];
    end
  end

  // System interrupt level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(irqStat_reg & irqMask_reg);
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      unique case (regAddr)
        pise_pkg::MISC_ADDR: regRdata <= {7'h00, pendState, enable_reg}; // RULE1 RULE2
        pise_pkg::CFG_ADDR: regRdata <= {13'h0000, cfg_reg};
        pise_pkg::IRQ_STAT_ADDR: regRdata <= {14'h0000, irqStat_reg};
        pise_pkg::IRQ_MASK_ADDR: regRdata <= {14'h0000, irqMask_reg};
        default: regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  // ==========================================================
  // Checks
  // Each source check sees the one-cycle pulse after the edge detector,
  // so the interrupt line must follow at the very next edge.

  // Bit 8 source and its clear by the read
  a_pend_read_clear: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE1
    (miscRead && !pendSet) |=> !pendState) else $error("pending not cleared by read");
  a_pend_rx_src: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE1
    (!altMode && rxEv) |=> pendState) else $error("rx error half-full not latched");
  a_pend_mode_src: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE2
    (altMode && cfEv) |=> pendState) else $error("control frame not latched");

  // Enable register write and read back
  a_en_write_take: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE3
    wrHit(regAddr, regWrite, pise_pkg::MISC_ADDR) |=> enable_reg == $past(regWdata[7:0]))
    else $error("enable write lost");
  a_en_read_back: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE4
    miscRead |=> regRdata[7:0] == $past(enable_reg)) else $error("enable readback wrong");

  // One check per enabled source
  a_lq_enable_irq: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE3
    (enable_reg[pise_pkg::EN_LQ] && lqEv) |=> phyIrq)
    else $error("link quality irq missed");
  a_ed_enable_irq: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE4
    (enable_reg[pise_pkg::EN_ED] && edEv) |=> phyIrq)
    else $error("energy detect irq missed");
  a_link_enable_irq: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE5
    (enable_reg[pise_pkg::EN_LINK] && lnkEv) |=> phyIrq)
    else $error("link change irq missed");
  a_spd_enable_irq: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE6
    (enable_reg[pise_pkg::EN_SPD] && spdEv) |=> phyIrq)
    else $error("speed change irq missed");
  a_dup_sel_dup: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE7
    (!fnSel && enable_reg[pise_pkg::EN_DUP] && dupEv) |=> phyIrq)
    else $error("duplex irq missed");
  a_dup_sel_ts: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE7
    (fnSel && enable_reg[pise_pkg::EN_DUP] && tsGated) |=> phyIrq)
    else $error("time-sync irq missed");
  a_anc_enable_irq: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE8
    (enable_reg[pise_pkg::EN_ANC] && ancEv) |=> phyIrq)
    else $error("autoneg done irq missed");
  a_fc_mode_zero: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE9
    (!altMode && enable_reg[pise_pkg::EN_FC] && fcEv) |=> phyIrq)
    else $error("false carrier irq missed");
  a_ctr_alt_rx: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE10
    (altMode && enable_reg[pise_pkg::EN_FC] && rxEv) |=> phyIrq)
    else $error("counter irq missed");
  a_rx_mode_zero: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE11
    (!altMode && enable_reg[pise_pkg::EN_RX] && rxEv) |=> phyIrq)
    else $error("rx error irq missed");
  a_cf_alt_bit0: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE12
    (altMode && enable_reg[pise_pkg::EN_RX] && cfEv) |=> phyIrq)
    else $error("control frame irq missed");

  // Time-sync arming
  a_ts_rearm_hold: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE13
    (!tsArmed_reg && !tsEmpty) |=> !tsArmed_reg) else $error("time-sync rearmed early");

  // Interrupt lines
  a_irq_no_cause: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE14
    (!enPend_reg && !anyEnabled) |=> !phyIrq) else $error("spurious interrupt");
  a_irq_read_clear: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE14
    (miscRead && !anyEnabled) |=> !enPend_reg) else $error("pending irq not cleared");
  a_irq_mask_out: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (|(irqStat_reg & irqMask_reg)) |=> irqOut) else $error("masked irq missing");

  // Main scenarios
  c_pend_read: cover property (@(posedge sys_clk) disable iff (!reset_n)
    pendState ##1 miscRead ##1 !pendState);
  c_ts_rearm: cover property (@(posedge sys_clk) disable iff (!reset_n)
    !tsArmed_reg ##1 tsArmed_reg);
  c_irq_cycle: cover property (@(posedge sys_clk) disable iff (!reset_n)
    phyIrq ##[1:20] !phyIrq);
  c_ctr_alt: cover property (@(posedge sys_clk) disable iff (!reset_n)
    altMode && rxEv && enable_reg[pise_pkg::EN_FC]);
  c_ts_blocked: cover property (@(posedge sys_clk) disable iff (!reset_n)
    tsEv && !tsArmed_reg);

endmodule

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the interrupt status and event control block
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ==========================================================
  // Row of the event table: source, mode, enables, expected results
  typedef struct {int ev; logic [2:0] cfg; logic [7:0] en; logic irq; logic pend;} pise_row_s;

  // ==========================================================
  // Design connections
  logic sys_clk = 1'h0; // 125 MHz clock
  logic reset_n = 1'h0; // Held low at start
  logic [4:0] regAddr = 5'h00; // Register address
  logic [15:0] regWdata = 16'h0000; // Write data
  logic regWrite = 1'h0; // Write strobe
  logic regRead = 1'h0; // Read strobe
  logic [15:0] regRdata; // Read data
  logic [9:0] ev = 10'h000; // Event pins, one bit each
  logic tsEmpty = 1'h1; // Time-sync status empty
  logic phyIrq; // Device interrupt
  logic irqOut; // Masked sticky interrupt
  int miscompares = 0; // Mismatch count
  int compares = 0; // Comparison count
  logic [15:0] rdVal; // Last read value
  logic [4:0] regList [4] = '{5'h12, 5'h1a, 5'h1b, 5'h1c}; // Mapped registers

  // Ordinary cases: ev 0 lq,1 ed,2 link,3 spd,4 dup,5 ts,6 an,7 fc,8 rx,9 cf
  pise_row_s rows [16] = '{
    '{0, 3'h0, 8'h80, 1'h1, 1'h0},
    '{1, 3'h0, 8'h40, 1'h1, 1'h0},
    '{2, 3'h0, 8'h20, 1'h1, 1'h0},
    '{3, 3'h0, 8'h10, 1'h1, 1'h0},
    '{4, 3'h0, 8'h08, 1'h1, 1'h0},
    '{5, 3'h4, 8'h08, 1'h1, 1'h0},
    '{4, 3'h4, 8'h08, 1'h0, 1'h0},
    '{6, 3'h0, 8'h04, 1'h1, 1'h0},
    '{7, 3'h0, 8'h02, 1'h1, 1'h0},
    '{8, 3'h0, 8'h02, 1'h0, 1'h1},
    '{8, 3'h1, 8'h02, 1'h1, 1'h0},
    '{7, 3'h2, 8'h02, 1'h1, 1'h0},
    '{8, 3'h0, 8'h01, 1'h1, 1'h1},
    '{9, 3'h3, 8'h01, 1'h1, 1'h1},
    '{9, 3'h0, 8'h01, 1'h0, 1'h0},
    '{0, 3'h0, 8'h00, 1'h0, 1'h0}
  };

  // Clock generator
  always #4 sys_clk = ~sys_clk;

  pise_top dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .linkQualityEvent(ev[0]), .energyDetectEvent(ev[1]), .linkChangeEvent(ev[2]),
    .speedChangeEvent(ev[3]), .duplexChangeEvent(ev[4]), .timeSyncEvent(ev[5]),
    .timeSyncStatusEmpty(tsEmpty), .autonegDoneEvent(ev[6]),
    .falseCarrierHalfFull(ev[7]), .rxErrorHalfFull(ev[8]), .controlFrameEvent(ev[9]),
    .phyIrq(phyIrq), .irqOut(irqOut)
  );

  // ==========================================================
  // Bus and compare tasks
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge sys_clk);
    regWrite <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge sys_clk);
    regRead <= 1'h0;
    #1 d = regRdata;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkrd(input logic [4:0] a, input logic [15:0] e);
    rd(a, rdVal);
    chk("regRdata", e, rdVal);
  endtask

  // Edge on one pin, then time for sync, edge detect and interrupt register
  task automatic pulse(input int i);
    @(posedge sys_clk) ev[i] <= 1'h1;
    repeat (2) @(posedge sys_clk);
    ev[i] <= 1'h0;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'h1;
    wr(pise_pkg::IRQ_MASK_ADDR, 16'h0003);
    // Table of events against mode and enables
    foreach (rows[i]) begin
      wr(pise_pkg::CFG_ADDR, {13'h0000, rows[i].cfg});
      wr(pise_pkg::MISC_ADDR, {8'h00, rows[i].en});
      pulse(rows[i].ev);
      chk("phyIrq", {15'h0000, rows[i].irq}, {15'h0000, phyIrq});
      chk("irqOut", {15'h0000, rows[i].irq | rows[i].pend}, {15'h0000, irqOut});
      chkrd(pise_pkg::MISC_ADDR, {7'h00, rows[i].pend, rows[i].en});
      chkrd(pise_pkg::MISC_ADDR, {8'h00, rows[i].en});
      chk("phyIrq", 16'h0000, {15'h0000, phyIrq});
      chkrd(pise_pkg::IRQ_STAT_ADDR, {14'h0000, rows[i].irq, rows[i].pend});
      wr(pise_pkg::IRQ_STAT_ADDR, 16'h0003);
      chkrd(pise_pkg::IRQ_STAT_ADDR, 16'h0000);
    end
    // Time-sync rearm waits for empty status
    @(posedge sys_clk) tsEmpty <= 1'h0;
    wr(pise_pkg::CFG_ADDR, 16'h0004);
    wr(pise_pkg::MISC_ADDR, 16'h0008);
    pulse(5);
    chk("phyIrq", 16'h0001, {15'h0000, phyIrq});
    rd(pise_pkg::MISC_ADDR, rdVal);
    pulse(5);
    chk("phyIrq", 16'h0000, {15'h0000, phyIrq});
    @(posedge sys_clk) tsEmpty <= 1'h1;
    pulse(5);
    chk("phyIrq", 16'h0001, {15'h0000, phyIrq});
    rd(pise_pkg::MISC_ADDR, rdVal);
    wr(pise_pkg::IRQ_STAT_ADDR, 16'h0003);
    // Masked sticky status holds the output low until unmasked
    wr(pise_pkg::IRQ_MASK_ADDR, 16'h0000);
    wr(pise_pkg::CFG_ADDR, 16'h0000);
    wr(pise_pkg::MISC_ADDR, 16'h0020);
    pulse(2);
    chk("irqOut", 16'h0000, {15'h0000, irqOut});
    chkrd(pise_pkg::IRQ_STAT_ADDR, 16'h0002);
    wr(pise_pkg::IRQ_MASK_ADDR, 16'h0002);
    repeat (2) @(posedge sys_clk);
    #1 chk("irqOut", 16'h0001, {15'h0000, irqOut});
    wr(pise_pkg::IRQ_STAT_ADDR, 16'h0002);
    repeat (2) @(posedge sys_clk);
    #1 chk("irqOut", 16'h0000, {15'h0000, irqOut});
    // Read-only pending bit, unmapped place, then a reset in mid-run
    rd(pise_pkg::MISC_ADDR, rdVal);
    wr(pise_pkg::MISC_ADDR, 16'hffff);
    chkrd(pise_pkg::MISC_ADDR, 16'h00ff);
    wr(pise_pkg::CFG_ADDR, 16'h0007);
    chkrd(pise_pkg::CFG_ADDR, 16'h0007);
    wr(5'h05, 16'hffff);
    chkrd(5'h05, 16'h0000);
    @(posedge sys_clk) reset_n <= 1'h0;
    repeat (5) @(posedge sys_clk);
    #1 chk("phyIrq", 16'h0000, {15'h0000, phyIrq});
    chk("irqOut", 16'h0000, {15'h0000, irqOut});
    @(posedge sys_clk) reset_n <= 1'h1;
    foreach (regList[i]) begin
      chkrd(regList[i], 16'h0000);
    end
    print_verdict();
  end
endmodule

`default_nettype wire
